/* src/pbmcu_top.sv */
// Overview of operation
// - Decode 3-bit opcode; zero does nothing
// - Opcode 1 allocates transmit memory
// - Opcode 2 resets whole buffer manager
// - Opcode 3 drops receive queue head
// - Opcode 4 drops head and frees memory
// - Opcode 5 frees selected packet pages
// - Opcode 6 enqueues selected packet
// - Opcode 7 empties both transmit queues
// - Busy flag readable at bit 0
// - Busy and failed set after write
// - Packet select feeds area and commands
// - Packet select cleared by resets
// - Allocation result updated per allocate
// - Failed flag rules and reset high
// - Result holds last granted packet
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pbmcu_regs.svh"
module pbmcu_top (
  input  wire logic        clock,          // 50 MHz clock
  input  wire logic        rstn,           // Async reset, active low
  input  wire logic [3:0]  addr,           // Register index
  input  wire logic [15:0] wdata,          // Write data
  input  wire logic        wr,             // Write strobe
  input  wire logic        rd,             // Read strobe
  output logic      [15:0] rdata,          // Read data, cycle after rd
  output logic      [5:0]  tx_area_packet, // Packet seen by the transmit area
  output logic      [5:0]  rx_head_packet, // Packet at receive queue output
  output logic             rx_empty,       // Receive queue empty
  output logic             tx_queue_push,  // Pulse: packet enqueued
  output logic      [5:0]  tx_queue_data,  // Packet being enqueued
  output logic             tx_queues_clear,// Pulse: transmit queues emptied
  output logic             allocation_done_flag, // Allocation finished
  input  wire logic        done_ack,       // Clears allocation_done_flag
  input  wire logic        rx_push,        // Received frame stored
  input  wire logic [5:0]  rx_push_pkt     // Its packet number
);
  localparam int NPKT = 64;

  logic [5:0]  tx_area_packet_select_reg;
  logic [7:0]  allocation_outcome_reg;
  logic        busy_reg;
  logic [3:0]  rel_cnt_reg;
  logic [NPKT-1:0] owned_reg;
  logic [5:0]  rxq_mem [0:7];
  logic [2:0]  rxq_rd_reg, rxq_wr_reg;
  logic [3:0]  rxq_cnt_reg;
  logic        alloc_pend_reg;
  logic [5:0]  rel_pkt_reg;
  pbmcu_pkg::pbmcu_state_e state_reg;

  logic        cmd_wr;
  pbmcu_pkg::pbmcu_op_e op;
  logic        free_ok;
  logic [5:0]  free_pkt;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign cmd_wr = wr && addr == `PBMCU_CMD_OFS;
  assign op = pbmcu_pkg::pbmcu_op_e'(wdata[`PBMCU_OP_MSB:`PBMCU_OP_LSB]);

  function automatic logic [6:0] first_free(input logic [NPKT-1:0] own);
    logic [6:0] r;
    r = 7'h00;
    for (int i = NPKT - 1; i >= 0; i--) begin
      if (!own[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction : first_free

  assign {free_ok, free_pkt} = first_free(owned_reg);

  // ----------------------------------------------------------------
  // Packet select register
  // ----------------------------------------------------------------
  // cleared by resets
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_area_packet_select_reg <= 6'(`PBMCU_SEL_RST);
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      tx_area_packet_select_reg <= 6'(`PBMCU_SEL_RST);
    end else if (wr && addr == `PBMCU_SEL_OFS) begin
      tx_area_packet_select_reg <= wdata[5:0];
    end
  end
  assign tx_area_packet = tx_area_packet_select_reg;

  // ----------------------------------------------------------------
  // Allocation
  // ----------------------------------------------------------------
  // allocate on opcode 1; result update; failed flag
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      allocation_outcome_reg <= `PBMCU_RES_RST;
      alloc_pend_reg         <= 1'b0;
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      allocation_outcome_reg <= `PBMCU_RES_RST;
      alloc_pend_reg         <= 1'b0;
    end else if (cmd_wr && op == pbmcu_pkg::OP_ALLOC) begin
      // failed set at command end, cleared on the grant
      allocation_outcome_reg[`PBMCU_FAILED_BIT] <= 1'b1;
      alloc_pend_reg <= 1'b1;
    end else if (alloc_pend_reg && free_ok && state_reg == pbmcu_pkg::ST_IDLE && !cmd_wr) begin
      // Any command write defers the grant, matching the ownership map and done flag
      // granted number held
      allocation_outcome_reg <= {2'b00, free_pkt};
      alloc_pend_reg         <= 1'b0;
    end
  end

  // Done flag: grant sets, ack clears, set wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      allocation_done_flag <= 1'b0;
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      allocation_done_flag <= 1'b0;
    end else if (alloc_pend_reg && free_ok && state_reg == pbmcu_pkg::ST_IDLE
                 && !cmd_wr) begin
      allocation_done_flag <= 1'b1;
    end else if (done_ack) begin
      allocation_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Ownership map and release engine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      owned_reg <= '0;
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      owned_reg <= '0;
    end else begin
      if (alloc_pend_reg && free_ok && state_reg == pbmcu_pkg::ST_IDLE && !cmd_wr) begin
        owned_reg[free_pkt] <= 1'b1;
      end
      if (state_reg == pbmcu_pkg::ST_REL && rel_cnt_reg == 4'h1) begin
        owned_reg[rel_pkt_reg] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= pbmcu_pkg::ST_IDLE;
      busy_reg    <= 1'b0;
      rel_cnt_reg <= 4'h0;
      rel_pkt_reg <= 6'h00;
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      state_reg   <= pbmcu_pkg::ST_IDLE;
      busy_reg    <= 1'b0;
      rel_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        pbmcu_pkg::ST_IDLE: begin
          // release start; busy at command end
          if (cmd_wr && (op == pbmcu_pkg::OP_RXREL || op == pbmcu_pkg::OP_PKTREL)) begin
            state_reg   <= pbmcu_pkg::ST_REL;
            busy_reg    <= 1'b1;
            rel_cnt_reg <= `PBMCU_REL_CYCLES;
            rel_pkt_reg <= (op == pbmcu_pkg::OP_RXREL) ? rx_head_packet
                                                       : tx_area_packet_select_reg;
          end
        end
        pbmcu_pkg::ST_REL: begin
          rel_cnt_reg <= rel_cnt_reg - 4'h1;
          if (rel_cnt_reg == 4'h1) begin
            state_reg <= pbmcu_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= pbmcu_pkg::ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  logic rx_pop;
  logic rx_in;
  // drop head on opcode 3 or 4
  assign rx_pop = cmd_wr && rxq_cnt_reg != 4'h0
                  && (op == pbmcu_pkg::OP_RXDROP || op == pbmcu_pkg::OP_RXREL);
  assign rx_in  = rx_push && rxq_cnt_reg != 4'h8;

  always_ff @(posedge clock) begin
    if (rx_in) begin
      rxq_mem[rxq_wr_reg] <= rx_push_pkt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxq_rd_reg  <= 3'h0;
      rxq_wr_reg  <= 3'h0;
      rxq_cnt_reg <= 4'h0;
    end else if (cmd_wr && op == pbmcu_pkg::OP_RESET) begin
      rxq_rd_reg  <= 3'h0;
      rxq_wr_reg  <= 3'h0;
      rxq_cnt_reg <= 4'h0;
    end else begin
      if (rx_pop) begin
        rxq_rd_reg <= rxq_rd_reg + 3'h1;
      end
      if (rx_in) begin
        rxq_wr_reg <= rxq_wr_reg + 3'h1;
      end
      rxq_cnt_reg <= rxq_cnt_reg + {3'h0, rx_in} - {3'h0, rx_pop};
    end
  end
  assign rx_head_packet = rxq_cnt_reg != 4'h0 ? rxq_mem[rxq_rd_reg] : 6'h00;
  assign rx_empty       = rxq_cnt_reg == 4'h0;

  // ----------------------------------------------------------------
  // Transmit queue strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_queue_push   <= 1'b0;
      tx_queue_data   <= 6'h00;
      tx_queues_clear <= 1'b0;
    end else begin
      tx_queue_push   <= cmd_wr && op == pbmcu_pkg::OP_ENQ;
      tx_queue_data   <= tx_area_packet_select_reg;
      // clear queues, memory untouched; also on manager reset
      tx_queues_clear <= cmd_wr && (op == pbmcu_pkg::OP_TXRST || op == pbmcu_pkg::OP_RESET);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `PBMCU_CMD_OFS: rdata <= {15'h0000, busy_reg};
        `PBMCU_SEL_OFS: rdata <= {10'h000, tx_area_packet_select_reg};
        `PBMCU_RES_OFS: rdata <= {8'h00, allocation_outcome_reg};
        default:        rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_BUSY_ON_REL: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_PKTREL && !busy_reg) |=> busy_reg)
    else $error("busy not set after release");
  AST_BUSY_LEN: assert property (@(posedge clock) disable iff (!rstn)
    $rose(busy_reg) && !(cmd_wr && op == pbmcu_pkg::OP_RESET) |-> busy_reg[*4])
    else $error("busy too short");
  AST_BUSY_END: assert property (@(posedge clock) disable iff (!rstn)
    $rose(busy_reg) |-> ##[1:5] !busy_reg)
    else $error("busy did not end");
  AST_FAIL_SET: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_ALLOC) |=> allocation_outcome_reg[7])
    else $error("failed not set");
  AST_RESET_CMD: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_RESET) |=>
      tx_area_packet_select_reg == 6'h00 && allocation_outcome_reg == 8'h80)
    else $error("reset opcode incomplete");
  AST_ENQ: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_ENQ) |=>
      tx_queue_push && tx_queue_data == $past(tx_area_packet_select_reg))
    else $error("enqueue missing");
  AST_TXRST: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_TXRST) |=> tx_queues_clear && $stable(owned_reg))
    else $error("queue reset wrong");
  AST_RXPOP: assert property (@(posedge clock) disable iff (!rstn)
    (rx_pop && !rx_in) |=> rxq_cnt_reg == $past(rxq_cnt_reg) - 4'h1)
    else $error("receive head not dropped");
  AST_IDLE_OP: assert property (@(posedge clock) disable iff (!rstn)
    (cmd_wr && op == pbmcu_pkg::OP_IDLE && !busy_reg) |=> !busy_reg && !tx_queue_push)
    else $error("idle opcode acted");
  AST_GRANT: assert property (@(posedge clock) disable iff (!rstn)
    $fell(allocation_outcome_reg[7]) |-> owned_reg[allocation_outcome_reg[5:0]])
    else $error("grant not owned");
  COV_ALLOC: cover property (@(posedge clock) disable iff (!rstn)
    $fell(allocation_outcome_reg[7]));
  COV_REL: cover property (@(posedge clock) disable iff (!rstn) $fell(busy_reg));
  COV_ENQ: cover property (@(posedge clock) disable iff (!rstn) tx_queue_push);
endmodule : pbmcu_top
`default_nettype wire

/* src/pbmcu_regs.svh */
`ifndef PBMCU_REGS_SVH
`define PBMCU_REGS_SVH
// Register indices on the word port
`define PBMCU_CMD_OFS        4'h0
`define PBMCU_SEL_OFS        4'h2
`define PBMCU_RES_OFS        4'h3
`define PBMCU_PGCNT_OFS      4'h4
// Field positions
`define PBMCU_OP_LSB         5
`define PBMCU_OP_MSB         7
`define PBMCU_BUSY_BIT       0
`define PBMCU_FAILED_BIT     7
// Reset values
`define PBMCU_SEL_RST        8'h00
`define PBMCU_RES_RST        8'h80
`define PBMCU_PAGES_RST      8'h20
// Release duration in clocks
`define PBMCU_REL_CYCLES     4'h4
`endif

/* src/pbmcu_pkg.sv */
`default_nettype none
package pbmcu_pkg;
  typedef enum logic [2:0] {
    OP_IDLE    = 3'h0,
    OP_ALLOC   = 3'h1,
    OP_RESET   = 3'h2,
    OP_RXDROP  = 3'h3,
    OP_RXREL   = 3'h4,
    OP_PKTREL  = 3'h5,
    OP_ENQ     = 3'h6,
    OP_TXRST   = 3'h7
  } pbmcu_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REL  = 2'b10
  } pbmcu_state_e;
endpackage : pbmcu_pkg
`default_nettype wire

/* bench/pbmcu_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pbmcu_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("BAD t=%0t value mismatch got %h exp %h", $time, got, exp); end end
module pbmcu_top_test;
  logic        clock       = 1'b0;
  logic        rstn        = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic [15:0] wdata       = 16'h0000;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic        done_ack    = 1'b0;
  logic        rx_push     = 1'b0;
  logic [5:0]  rx_push_pkt = 6'h00;
  logic [15:0] rdata;
  logic [5:0]  tx_area_packet;
  logic [5:0]  rx_head_packet;
  logic        rx_empty;
  logic        tx_queue_push;
  logic [5:0]  tx_queue_data;
  logic        tx_queues_clear;
  logic        allocation_done_flag;
  logic [15:0] rv;
  int          errors      = 0;
  int          tests_run   = 0;
  int          push_cnt    = 0;
  int          clr_cnt     = 0;
  logic [5:0]  push_last   = 6'h00;

  always #10 clock = ~clock;

  pbmcu_top pbmcu_top_inst (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_area_packet(tx_area_packet), .rx_head_packet(rx_head_packet),
    .rx_empty(rx_empty), .tx_queue_push(tx_queue_push), .tx_queue_data(tx_queue_data),
    .tx_queues_clear(tx_queues_clear), .allocation_done_flag(allocation_done_flag),
    .done_ack(done_ack), .rx_push(rx_push), .rx_push_pkt(rx_push_pkt)
  );

  // Pulses are counted here so no test has to guess their exact cycle
  always @(posedge clock) begin
    if (tx_queue_push === 1'b1) begin
      push_cnt++;
      push_last = tx_queue_data;
    end
    if (tx_queues_clear === 1'b1) clr_cnt++;
  end

  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg

  task automatic cmd(input logic [2:0] op);
    wr_reg(`PBMCU_CMD_OFS, {8'h00, op, 5'h00});
  endtask : cmd

  // Allocation: wait for done flag, read result, acknowledge if granted
  task automatic alloc(input logic [7:0] exp, input logic ok);
    int i;
    cmd(3'h1);
    for (i = 0; i < 20 && allocation_done_flag !== 1'b1; i++) @(posedge clock);
    `CHK(allocation_done_flag, ok)
    rd_reg(`PBMCU_RES_OFS);
    `CHK(rv, {8'h00, exp})
    if (ok) begin
      @(posedge clock);
      done_ack <= 1'b1;
      @(posedge clock);
      done_ack <= 1'b0;
      #1 `CHK(allocation_done_flag, 1'b0)
    end
  endtask : alloc

  task automatic release_wait();
    rd_reg(`PBMCU_CMD_OFS);
    `CHK(rv[`PBMCU_BUSY_BIT], 1'b1)
    repeat (8) @(posedge clock);
    rd_reg(`PBMCU_CMD_OFS);
    `CHK(rv[`PBMCU_BUSY_BIT], 1'b0)
  endtask : release_wait

  task automatic push(input logic [5:0] p);
    @(posedge clock);
    rx_push     <= 1'b1;
    rx_push_pkt <= p;
    @(posedge clock);
    rx_push     <= 1'b0;
  endtask : push

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    int i;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(`PBMCU_SEL_OFS);
    `CHK(rv, 16'h0000)
    rd_reg(`PBMCU_RES_OFS);
    `CHK(rv, 16'h0080)
    rd_reg(4'hF);
    `CHK(rv, 16'h0000)
    $display("reset values done");
    alloc(8'h00, 1'b1);
    alloc(8'h01, 1'b1);
    alloc(8'h02, 1'b1);
    wr_reg(`PBMCU_SEL_OFS, 16'h0002);
    cmd(3'h6);
    repeat (3) @(posedge clock);
    `CHK(push_cnt, 1)
    `CHK(push_last, 6'h02)
    `CHK(tx_area_packet, 6'h02)
    // Packet 2 now waits for transmission, so no release may touch it
    wr_reg(`PBMCU_SEL_OFS, 16'h0001);
    cmd(3'h5);
    release_wait();
    alloc(8'h01, 1'b1);
    $display("alloc enqueue release done");
    push(6'h00);
    push(6'h01);
    #1 `CHK(rx_empty, 1'b0)
    `CHK(rx_head_packet, 6'h00)
    cmd(3'h3);
    repeat (2) @(posedge clock);
    #1 `CHK(rx_head_packet, 6'h01)
    cmd(3'h4);
    release_wait();
    `CHK(rx_empty, 1'b1)
    alloc(8'h01, 1'b1);
    $display("receive queue done");
    cmd(3'h0);
    cmd(3'h7);
    repeat (3) @(posedge clock);
    `CHK(push_cnt, 1)
    `CHK(clr_cnt, 1)
    rd_reg(`PBMCU_RES_OFS);
    `CHK(rv, 16'h0001)
    cmd(3'h2);
    repeat (3) @(posedge clock);
    `CHK(clr_cnt, 2)
    rd_reg(`PBMCU_SEL_OFS);
    `CHK(rv, 16'h0000)
    rd_reg(`PBMCU_RES_OFS);
    `CHK(rv, 16'h0080)
    $display("idle and resets done");
    // All 64 packets in turn, then one too many stays pending
    for (i = 0; i < 64; i++) alloc(i[7:0], 1'b1);
    // Failed is set while the packet field keeps the last grant
    alloc(8'hBF, 1'b0);
    wr_reg(`PBMCU_SEL_OFS, 16'h0005);
    cmd(3'h5);
    for (i = 0; i < 30 && allocation_done_flag !== 1'b1; i++) @(posedge clock);
    `CHK(allocation_done_flag, 1'b1)
    rd_reg(`PBMCU_RES_OFS);
    `CHK(rv, 16'h0005)
    $display("exhaustion done");
    end_of_test();
  end
endmodule : pbmcu_top_test
`default_nettype wire
